/* logic/analog_io_pkg.sv */
// package: register offsets, field positions, timing and carrier types of the analog i/o control
// assumes a 250 MHz clock and a 16-bit word bus with byte offsets relative to the board base
package analog_io_pkg;

  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned SETTLE_TIME_NS = 15000;
  localparam int unsigned CONV_TIME_NS   = 25000;
  // least times, so round up
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned COUNT_W        = 16;

  localparam logic [2:0] OFS_CSR   = 3'h0;
  localparam logic [2:0] OFS_DBR   = 3'h2;
  localparam logic [2:0] OFS_DAC_A = 3'h4;
  localparam logic [2:0] OFS_DAC_B = 3'h6;

  localparam int CSR_START  = 0;
  localparam int CSR_GAIN0  = 2;
  localparam int CSR_GAIN1  = 3;
  localparam int CSR_EXT_EN = 4;
  localparam int CSR_RTC_EN = 5;
  localparam int CSR_DONEIE = 6;
  localparam int CSR_DONE   = 7;
  localparam int CSR_MUX_LO = 8;
  localparam int CSR_MUX_HI = 11;
  localparam int CSR_ERRIE  = 14;
  localparam int CSR_ERR    = 15;

  localparam int DATA_W = 12;
  localparam int SIGN_W = 4;

  localparam logic [1:0] NOTE_BINARY = 2'h0;
  localparam logic [1:0] NOTE_OFFSET = 2'h1;
  localparam logic [1:0] NOTE_TWOS   = 2'h2;

  localparam int unsigned VEC_W          = 9;
  localparam logic [8:0]  VEC_BASE_DEF   = 9'h100;
  localparam logic [8:0]  VEC_ERR_OFFSET = 9'h004;
  localparam logic [3:0]  GAIN_UNIT      = 4'h1;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } busReq_t;

  typedef struct packed {
    logic       inputModeJumper;
    logic       triggerSourceJumperOne;
    logic       triggerSourceJumperTwo;
    logic [1:0] notation;
  } jumpers_t;

  typedef enum logic [3:0] {
    SEQ_IDLE    = 4'b0001,
    SEQ_SETTLE  = 4'b0010,
    SEQ_PENDING = 4'b0100,
    SEQ_CONVERT = 4'b1000
  } seqState_t;

endpackage

/* logic/conv_sequencer.sv */
// sample-and-hold and converter timing: settling after reconfiguration, then a fixed conversion time
// assumes start requests arrive already screened for errors by the register logic
module conv_sequencer
  import analog_io_pkg::*;
#(
  parameter int unsigned CONV_COUNT = analog_io_pkg::CONV_CYCLES
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic busInit,
  input  wire logic settleStart,
  input  wire logic convStart,
  output logic      holdMode,
  output logic      converterStart,
  output logic      convDone,
  output logic      settling,
  output logic      converting
);

  typedef struct packed {
    seqState_t            state;
    logic [COUNT_W-1:0]   count;
    logic                 hold;
    logic                 go;
    logic                 done;
    logic                 settling;
    logic                 busy;
  } seqReg_t;

  localparam logic [COUNT_W-1:0] SETTLE_LOAD = COUNT_W'(SETTLE_CYCLES - 1);
  localparam logic [COUNT_W-1:0] CONV_LOAD   = COUNT_W'(CONV_COUNT - 1);

  seqReg_t s_reg;
  seqReg_t s_next;

  always_comb
  begin
    s_next      = s_reg;
    s_next.go   = 1'b0;
    s_next.done = 1'b0;
    if (s_reg.count != '0)
    begin
      s_next.count = s_reg.count - 1'b1;
    end
    case (s_reg.state)
      SEQ_IDLE:
      begin
        if (convStart && settleStart)
        begin
          s_next.state = SEQ_PENDING;
          s_next.count = SETTLE_LOAD;
        end
        else if (convStart)
        begin
          s_next.state = SEQ_CONVERT;
          s_next.count = CONV_LOAD;
          s_next.hold  = 1'b1;
          s_next.go    = 1'b1;
        end
        else if (settleStart)
        begin
          s_next.state = SEQ_SETTLE;
          s_next.count = SETTLE_LOAD;
        end
      end
      SEQ_SETTLE:
      begin
        if (settleStart)
        begin
          s_next.count = SETTLE_LOAD;
        end
        if (convStart)
        begin
          s_next.state = SEQ_PENDING;
        end
        else if (s_reg.count == '0 && !settleStart)
        begin
          s_next.state = SEQ_IDLE;
        end
      end
      SEQ_PENDING:
      begin
        if (s_reg.count == '0)
        begin
          s_next.state = SEQ_CONVERT;
          s_next.count = CONV_LOAD;
          s_next.hold  = 1'b1;
          s_next.go    = 1'b1;
        end
      end
      SEQ_CONVERT:
      begin
        if (s_reg.count == '0)
        begin
          s_next.state = SEQ_IDLE;
          s_next.hold  = 1'b0;
          s_next.done  = 1'b1;
        end
      end
      default:
      begin
        s_next.state = SEQ_IDLE;
        s_next.hold  = 1'b0;
      end
    endcase
    if (busInit)
    begin
      s_next.state = SEQ_IDLE;
      s_next.count = '0;
      s_next.hold  = 1'b0;
      s_next.go    = 1'b0;
      s_next.done  = 1'b0;
    end
    s_next.settling = (s_next.state == SEQ_SETTLE) || (s_next.state == SEQ_PENDING);
    s_next.busy     = (s_next.state == SEQ_PENDING) || (s_next.state == SEQ_CONVERT);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{state: SEQ_IDLE, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign holdMode       = s_reg.hold;
  assign converterStart = s_reg.go;
  assign convDone       = s_reg.done;
  assign settling       = s_reg.settling;
  assign converting     = s_reg.busy;

endmodule

/* logic/analog_io_conversion_control.sv */
// analog i/o board control: control/status, result and two analog output registers on the host bus
// assumes all inputs synchronous to clk; bus read/write are one-cycle strobes with a byte offset
module analog_io_conversion_control
  import analog_io_pkg::*;
#(
  parameter int unsigned CONV_COUNT = analog_io_pkg::CONV_CYCLES,
  parameter logic [8:0]  VEC_BASE   = analog_io_pkg::VEC_BASE_DEF
)
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire analog_io_pkg::busReq_t  busReq,
  input  wire logic                    busInit,
  input  wire logic                    intAck,
  input  wire logic                    busEventLine,
  input  wire logic                    extTrigPin,
  input  wire logic                    rtcPulse,
  input  wire analog_io_pkg::jumpers_t jumpers,
  input  wire logic [11:0]             adcData,
  output logic [15:0]                  busRdata,
  output logic                         irqDone,
  output logic                         irqError,
  output logic [8:0]                   vectorOut,
  output logic                         vectorValid,
  output logic [3:0]                   muxChannel,
  output logic                         differentialMode,
  output logic [1:0]                   gainSelect,
  output logic [3:0]                   gainFactor,
  output logic                         sampleHold,
  output logic                         converterStart,
  output logic [11:0]                  analogOutA,
  output logic [11:0]                  analogOutB,
  output logic                         analogOutALoad,
  output logic                         analogOutBLoad
);

  typedef struct packed {
    logic [1:0]  gain;
    logic        extEn;
    logic        rtcEn;
    logic        doneIe;
    logic        done;
    logic [3:0]  mux;
    logic        errIe;
    logic        err;
    logic [15:0] result;
    logic [15:0] rdata;
    logic [11:0] dacA;
    logic [11:0] dacB;
    logic        loadA;
    logic        loadB;
    logic        extPrev;
    logic        rtcPrev;
    logic        irqDone;
    logic        irqErr;
    logic [8:0]  vector;
    logic        vectorValid;
    logic        diffMode;
    logic [3:0]  muxOut;
    logic [3:0]  gainFactor;
  } ctlReg_t;

  ctlReg_t s_reg;
  ctlReg_t s_next;

  logic seqDone;
  logic seqSettling;
  logic seqBusy;
  logic csrWrite;
  logic resultRead;
  logic extSel;
  logic progStart;
  logic extStart;
  logic rtcStart;
  logic anyStart;
  logic startErr;
  logic convStart;
  logic [15:0] coded;
  logic [15:0] csrWord;
  logic [1:0]  dacWrite;

  conv_sequencer #(
    .CONV_COUNT (CONV_COUNT)
  ) sequencer (
    .clk            (clk),
    .arst_n         (arst_n),
    .busInit        (busInit),
    .settleStart    (csrWrite),
    .convStart      (convStart),
    .holdMode       (sampleHold),
    .converterStart (converterStart),
    .convDone       (seqDone),
    .settling       (seqSettling),
    .converting     (seqBusy)
  );

  // one write decode per analog output channel, output A at index 0
  for (genvar ch = 0; ch < $bits(dacWrite); ch++)
  begin : gDacDecode
    assign dacWrite[ch] = busReq.write && (busReq.addr == ((ch == 0) ? OFS_DAC_A : OFS_DAC_B));
  end

  always_comb
  begin
    csrWrite   = busReq.write && (busReq.addr == OFS_CSR);
    resultRead = busReq.read && (busReq.addr == OFS_DBR);
    // bus event line only when the first jumper is in and the second out
    extSel     = (jumpers.triggerSourceJumperOne && !jumpers.triggerSourceJumperTwo) ?
                 busEventLine : extTrigPin;
    progStart  = csrWrite && busReq.wdata[CSR_START];
    extStart   = extSel && !s_reg.extPrev && s_reg.extEn;
    rtcStart   = rtcPulse && !s_reg.rtcPrev && s_reg.rtcEn;
    anyStart   = progStart || extStart || rtcStart;
    startErr   = (anyStart && (s_reg.done || seqBusy)) ||
                 ((extStart || rtcStart) && seqSettling);
    // a refused start never reaches the sequencer, so a running conversion is left alone
    convStart  = anyStart && !startErr;

    case (jumpers.notation)
      NOTE_TWOS:
      begin
        coded = {{SIGN_W{~adcData[DATA_W-1]}}, ~adcData[DATA_W-1], adcData[DATA_W-2:0]};
      end
      default:
      begin
        coded = {{SIGN_W{1'b0}}, adcData};
      end
    endcase
  end

  // readback image of the control/status register; start and unused bits read zero
  always_comb
  begin
    csrWord                        = '0;
    csrWord[CSR_GAIN1:CSR_GAIN0]   = s_reg.gain;
    csrWord[CSR_EXT_EN]            = s_reg.extEn;
    csrWord[CSR_RTC_EN]            = s_reg.rtcEn;
    csrWord[CSR_DONEIE]            = s_reg.doneIe;
    csrWord[CSR_DONE]              = s_reg.done;
    csrWord[CSR_MUX_HI:CSR_MUX_LO] = s_reg.mux;
    csrWord[CSR_ERRIE]             = s_reg.errIe;
    csrWord[CSR_ERR]               = s_reg.err;
  end

  always_comb
  begin
    s_next             = s_reg;
    s_next.loadA       = 1'b0;
    s_next.loadB       = 1'b0;
    s_next.vectorValid = 1'b0;
    s_next.rdata       = '0;
    s_next.extPrev     = extSel;
    s_next.rtcPrev     = rtcPulse;

    if (csrWrite)
    begin
      s_next.gain   = busReq.wdata[CSR_GAIN1:CSR_GAIN0];
      s_next.extEn  = busReq.wdata[CSR_EXT_EN];
      s_next.rtcEn  = busReq.wdata[CSR_RTC_EN];
      s_next.doneIe = busReq.wdata[CSR_DONEIE];
      s_next.mux    = busReq.wdata[CSR_MUX_HI:CSR_MUX_LO];
      s_next.errIe  = busReq.wdata[CSR_ERRIE];
      s_next.err    = 1'b0;
    end
    if (dacWrite[0])
    begin
      s_next.dacA  = busReq.wdata[DATA_W-1:0];
      s_next.loadA = 1'b1;
    end
    if (dacWrite[1])
    begin
      s_next.dacB  = busReq.wdata[DATA_W-1:0];
      s_next.loadB = 1'b1;
    end
    if (resultRead)
    begin
      s_next.done = 1'b0;
    end
    if (busInit)
    begin
      s_next.done   = 1'b0;
      s_next.doneIe = 1'b0;
      s_next.err    = 1'b0;
      s_next.errIe  = 1'b0;
    end
    // hardware sets win over any clear in the same cycle
    if (seqDone)
    begin
      s_next.done   = 1'b1;
      s_next.result = coded;
    end
    if (startErr)
    begin
      s_next.err = 1'b1;
    end

    if (busReq.read)
    begin
      case (busReq.addr)
        OFS_CSR:
        begin
          s_next.rdata = csrWord;
        end
        OFS_DBR:
        begin
          s_next.rdata = s_reg.result;
        end
        default:
        begin
          s_next.rdata = '0;
        end
      endcase
    end

    // request rises when flag and enable become true together; drops on ack or loss of cause
    if (!(s_next.done && s_next.doneIe))
    begin
      s_next.irqDone = 1'b0;
    end
    else if (!(s_reg.done && s_reg.doneIe))
    begin
      s_next.irqDone = 1'b1;
    end
    if (!(s_next.err && s_next.errIe))
    begin
      s_next.irqErr = 1'b0;
    end
    else if (!(s_reg.err && s_reg.errIe))
    begin
      s_next.irqErr = 1'b1;
    end
    // done is served before error when both wait for the acknowledge
    if (intAck && s_reg.irqDone)
    begin
      s_next.irqDone     = 1'b0;
      s_next.vector      = VEC_BASE;
      s_next.vectorValid = 1'b1;
    end
    else if (intAck && s_reg.irqErr)
    begin
      s_next.irqErr      = 1'b0;
      s_next.vector      = VEC_BASE + VEC_ERR_OFFSET;
      s_next.vectorValid = 1'b1;
    end

    s_next.diffMode   = jumpers.inputModeJumper;
    s_next.muxOut     = jumpers.inputModeJumper ? {1'b0, s_next.mux[2:0]} : s_next.mux;
    s_next.gainFactor = GAIN_UNIT << s_next.gain;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{gainFactor: GAIN_UNIT, default: '0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign busRdata         = s_reg.rdata;
  assign irqDone          = s_reg.irqDone;
  assign irqError         = s_reg.irqErr;
  assign vectorOut        = s_reg.vector;
  assign vectorValid      = s_reg.vectorValid;
  assign muxChannel       = s_reg.muxOut;
  assign differentialMode = s_reg.diffMode;
  assign gainSelect       = s_reg.gain;
  assign gainFactor       = s_reg.gainFactor;
  assign analogOutA       = s_reg.dacA;
  assign analogOutB       = s_reg.dacB;
  assign analogOutALoad   = s_reg.loadA;
  assign analogOutBLoad   = s_reg.loadB;

endmodule

/* verification/analog_io_asserts.sv */
// checker: port timing of the analog i/o conversion control
// assumes it is bound to the top module and sees its ports only
module analog_io_asserts
  import analog_io_pkg::*;
#(
  parameter int unsigned CONV_COUNT = analog_io_pkg::CONV_CYCLES,
  parameter logic [8:0]  VEC_BASE   = analog_io_pkg::VEC_BASE_DEF
)
(
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire analog_io_pkg::busReq_t busReq,
  input wire logic                   intAck,
  input wire logic [15:0]            busRdata,
  input wire logic                   irqDone,
  input wire logic                   irqError,
  input wire logic [8:0]             vectorOut,
  input wire logic                   vectorValid,
  input wire logic [3:0]             muxChannel,
  input wire logic                   differentialMode,
  input wire logic [1:0]             gainSelect,
  input wire logic [3:0]             gainFactor,
  input wire logic                   sampleHold,
  input wire logic                   converterStart,
  input wire logic [11:0]            analogOutA,
  input wire logic [11:0]            analogOutB,
  input wire logic                   analogOutALoad,
  input wire logic                   analogOutBLoad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic wrA;
  logic wrB;
  logic wrCsr;
  assign wrA   = busReq.write && busReq.addr == OFS_DAC_A;
  assign wrB   = busReq.write && busReq.addr == OFS_DAC_B;
  assign wrCsr = busReq.write && busReq.addr == OFS_CSR;
  out_a_load_a: assert property (wrA |=> analogOutALoad && analogOutA == $past(busReq.wdata[11:0]))
    else $error("output A load wrong");
  out_b_load_a: assert property (wrB |=> analogOutBLoad && analogOutB == $past(busReq.wdata[11:0]))
    else $error("output B load wrong");
  load_cause_a: assert property (analogOutALoad || analogOutBLoad |-> $past(busReq.write) && $past(busReq.addr[2]))
    else $error("load pulse without write");
  gain_code_a: assert property (gainFactor == (4'h1 << gainSelect))
    else $error("gain factor wrong");
  csr_latch_a: assert property (wrCsr |=> gainSelect == $past(busReq.wdata[3:2])
    && muxChannel[2:0] == $past(busReq.wdata[10:8]))
    else $error("control fields not latched");
  start_zero_a: assert property (busReq.read && busReq.addr == OFS_CSR |=> !busRdata[0])
    else $error("start bit reads one");
  wo_read_a: assert property (busReq.read && busReq.addr[2] |=> busRdata == 16'h0)
    else $error("output register readable");
  diff_mux_a: assert property (differentialMode |-> !muxChannel[3])
    else $error("channel above 7 in differential mode");
  hold_conv_a: assert property (converterStart |-> ##[0:1] sampleHold ##1 sampleHold[*8])
    else $error("hold not kept during conversion");
  no_restart_a: assert property (converterStart |=> !converterStart[*8])
    else $error("conversion restarted");
  done_vec_a: assert property (intAck && irqDone |=> vectorValid && vectorOut == VEC_BASE)
    else $error("done vector wrong");
  err_vec_a: assert property (intAck && irqError && !irqDone |=> vectorValid
    && vectorOut == VEC_BASE + VEC_ERR_OFFSET)
    else $error("error vector wrong");
  cover property (converterStart);
  cover property (vectorValid && vectorOut == VEC_BASE + VEC_ERR_OFFSET);
  cover property (analogOutBLoad);
endmodule

/* verification/host_irq_model.sv */
// host model: acknowledges interrupt requests, alternately prompt and slow
// assumes requests stay up until acknowledged
module host_irq_model
  import analog_io_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       irqDone,
  input  wire logic       irqError,
  input  wire logic [8:0] vectorOut,
  input  wire logic       vectorValid,
  output logic            intAck,
  output logic [8:0]      lastVec
);
  timeunit 1ns;
  timeprecision 1ps;
  int delay = 1;
  initial
  begin
    intAck = 1'b0;
    forever
    begin
      @(posedge clk);
      if (arst_n && (irqDone || irqError))
      begin
        repeat (delay) @(posedge clk);
        intAck <= 1'b1;
        @(posedge clk);
        intAck <= 1'b0;
        delay = 7 - delay;
        repeat (2) @(posedge clk);
      end
    end
  end
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
      lastVec <= '0;
    else if (vectorValid)
      lastVec <= vectorOut;
endmodule

/* verification/tb_analog_io_conversion_control.sv */
// testbench: register-level tests of the analog i/o conversion control
// assumes the checker and host model are compiled before it
module tb_analog_io_conversion_control import analog_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV   = 20;
  localparam int unsigned SETTLE = SETTLE_CYCLES;
  logic clk, arst_n, busInit, intAck, busEventLine, extTrigPin, rtcPulse;
  busReq_t     busReq;
  jumpers_t    jumpers;
  logic [11:0] adcData, analogOutA, analogOutB;
  logic [15:0] busRdata, data;
  logic [8:0]  vectorOut, lastVec;
  logic [3:0]  muxChannel, gainFactor;
  logic [1:0]  gainSelect;
  logic irqDone, irqError, vectorValid, differentialMode, sampleHold, converterStart, analogOutALoad, analogOutBLoad;
  int badCount, cmpCount, cycles;
  analog_io_conversion_control #(.CONV_COUNT(CONV), .VEC_BASE(VEC_BASE_DEF)) dut (
    .clk, .arst_n, .busReq, .busInit, .intAck, .busEventLine, .extTrigPin, .rtcPulse, .jumpers, .adcData,
    .busRdata, .irqDone, .irqError, .vectorOut, .vectorValid, .muxChannel, .differentialMode, .gainSelect,
    .gainFactor, .sampleHold, .converterStart, .analogOutA, .analogOutB, .analogOutALoad, .analogOutBLoad);
  host_irq_model host (.clk, .arst_n, .irqDone, .irqError, .vectorOut, .vectorValid, .intAck, .lastVec);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    busReq <= '{1'b0, 1'b1, a, 16'h0};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
    data = busRdata;
  endtask
  // one-cycle event on the selected trigger lines: {clock, pin, bus event}
  task automatic trig(input logic [2:0] m);
    {rtcPulse, extTrigPin, busEventLine} <= m;
    @(posedge clk);
    {rtcPulse, extTrigPin, busEventLine} <= 3'h0;
  endtask
  task automatic waitConv();
    int n;
    n = 0;
    while (converterStart !== 1'b1 && n < SETTLE + 100)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(sampleHold), 16'h1);
    n = 0;
    while (sampleHold !== 1'b0 && n < CONV + 10)
    begin
      @(posedge clk);
      n++;
    end
    chk(16'(sampleHold), 16'h0);
    chk(16'(n), 16'(CONV));
    repeat (2) @(posedge clk);
  endtask
  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      badCount++;
      closeOut();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    busReq = '0;
    busInit = 1'b0;
    {rtcPulse, extTrigPin, busEventLine} = 3'h0;
    jumpers = '0;
    adcData = 12'h5a3;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(16'(gainFactor), 16'h1);
    chk(16'(sampleHold), 16'h0);
    for (int g = 0; g < 4; g++)
    begin
      jumpers.inputModeJumper <= g[0];
      wr(OFS_CSR, 16'h0f00 | 16'(g << 2));
      chk(16'(gainSelect), 16'(g));
      chk(16'(gainFactor), 16'(1 << g));
      chk(16'(muxChannel), g[0] ? 16'h7 : 16'hf);
      chk(16'(differentialMode), 16'(g[0]));
      rd(OFS_CSR);
      chk(data & 16'hf7ff, 16'h0700 | 16'(g << 2));
    end
    jumpers.inputModeJumper <= 1'b0;
    $display("test gain and channel done");
    wr(OFS_DAC_A, 16'hfabc);
    chk(16'(analogOutALoad), 16'h1);
    chk(16'(analogOutA), 16'h0abc);
    wr(OFS_DAC_B, 16'h0123);
    chk(16'(analogOutBLoad), 16'h1);
    chk(16'(analogOutB), 16'h0123);
    chk(16'(analogOutA), 16'h0abc);
    rd(OFS_DAC_B);
    chk(data, 16'h0);
    $display("test analog outputs done");
    wr(OFS_CSR, 16'h0341);
    waitConv();
    rd(OFS_CSR);
    chk(data, 16'h03c0);
    repeat (12) @(posedge clk);
    chk(16'(lastVec), 16'(VEC_BASE_DEF));
    wr(OFS_CSR, 16'h4301);
    repeat (12) @(posedge clk);
    chk(16'(sampleHold), 16'h0);
    chk(16'(lastVec), 16'(VEC_BASE_DEF + VEC_ERR_OFFSET));
    rd(OFS_CSR);
    chk(data, 16'hc380);
    rd(OFS_DBR);
    chk(data, 16'h05a3);
    rd(OFS_CSR);
    chk(data, 16'hc300);
    $display("test program start and error done");
    jumpers.notation <= NOTE_OFFSET;
    adcData <= 12'h800;
    wr(OFS_CSR, 16'h0020);
    repeat (SETTLE + 10) @(posedge clk);
    trig(3'h3);
    repeat (30) @(posedge clk);
    chk(16'(sampleHold), 16'h0);
    trig(3'h4);
    waitConv();
    rd(OFS_DBR);
    chk(data, 16'h0800);
    $display("test clock trigger done");
    jumpers <= '{1'b0, 1'b1, 1'b0, NOTE_TWOS};
    adcData <= 12'h000;
    wr(OFS_CSR, 16'h0050);
    repeat (SETTLE + 10) @(posedge clk);
    trig(3'h2);
    repeat (30) @(posedge clk);
    chk(16'(sampleHold), 16'h0);
    trig(3'h1);
    waitConv();
    busInit <= 1'b1;
    @(posedge clk);
    busInit <= 1'b0;
    @(posedge clk);
    rd(OFS_CSR);
    chk(data, 16'h0010);
    rd(OFS_DBR);
    chk(data, 16'hf800);
    $display("test external trigger done");
    closeOut();
  end
endmodule

bind analog_io_conversion_control analog_io_asserts #(.CONV_COUNT(CONV_COUNT), .VEC_BASE(VEC_BASE)) checks (
  .clk, .arst_n, .busReq, .intAck, .busRdata, .irqDone, .irqError, .vectorOut, .vectorValid, .muxChannel,
  .differentialMode, .gainSelect, .gainFactor, .sampleHold, .converterStart, .analogOutA, .analogOutB,
  .analogOutALoad, .analogOutBLoad);
